/* verilog/eic_consts.svh */
// Purpose: offsets, field positions and timing counts of the edge interrupt block
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   included by its bare name
`ifndef EIC_CONSTS_SVH
`define EIC_CONSTS_SVH

`define EIC_CLK_MHZ        100
`define EIC_TBASE_US       1000
`define EIC_TBASE_CYC      (`EIC_TBASE_US * `EIC_CLK_MHZ)
`define EIC_FILT_MS        10
`define EIC_FILT_CYC       (`EIC_FILT_MS * 1000 * `EIC_CLK_MHZ)
`define EIC_PER_MIN        7'h01
`define EIC_PER_MAX        7'h63

`define EIC_OFS_CFG        8'h00
`define EIC_OFS_DIS        8'h04
`define EIC_OFS_PER_A      8'h08
`define EIC_OFS_PER_B      8'h0C
`define EIC_OFS_PER_C      8'h10
`define EIC_OFS_STAT       8'h14
`define EIC_OFS_MASK       8'h18
`define EIC_OFS_ACK        8'h1C
`define EIC_OFS_PEND       8'h20
`define EIC_OFS_FILT       8'h24

`define EIC_CFG_GIE        0
`define EIC_CFG_MOTION     1
`define EIC_CFG_PER_EN     4
`define EIC_CFG_CNT_DIS    7
`define EIC_CFG_PLS_DIS    8

`define EIC_NSRC           32
`define EIC_SRC_FALL       0
`define EIC_SRC_RISE       8
`define EIC_SRC_PER        16
`define EIC_SRC_CNT        19
`define EIC_SRC_PLS        27

`define EIC_STAT_OVR       0
`define EIC_STAT_DISP      1

`endif

/* verilog/eic_pkg.sv */
// Purpose: types of the edge interrupt block
// Assumes: nothing
// Notes:   constants live in eic_consts.svh
package eic_pkg;
   typedef enum logic [2:0] {
      EIC_IDLE  = 3'b001,
      EIC_ISSUE = 3'b010,
      EIC_BUSY  = 3'b100
   } eic_disp_e;
   typedef logic [31:0] eic_word_t;
endpackage

/* verilog/eic_periodic.sv */
// Purpose: one periodic tick source on a 1 ms base
// Assumes: shared base pulse, period 1..99
// Notes:   out-of-range period holds the source silent
`timescale 1ns/100ps
`include "eic_consts.svh"
module eic_periodic (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       en,
   input  wire logic       base_tick,
   input  wire logic [6:0] period,
   output logic            tick
);
   import eic_pkg::*;

   typedef struct packed {
      logic [6:0] cnt;
      logic       tick;
   } eic_per_s;

   eic_per_s st;
   eic_per_s next_st;
   logic     ok;

   assign ok = (period >= `EIC_PER_MIN) && (period <= `EIC_PER_MAX);
   assign tick = st.tick;

   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (!en || !ok) begin
         next_st.cnt = 7'h00;
      end else if (base_tick) begin
         if (st.cnt + 7'h01 >= period) begin
            next_st.cnt = 7'h00;
            next_st.tick = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 7'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   a_tick_on_base: assert property (@(posedge aclk) disable iff (!aresetn)
      tick |-> $past(base_tick)) else $error("periodic tick without base pulse");
endmodule

/* verilog/eic_edge_in.sv */
// Purpose: per-input filter and edge detection
// Assumes: input synchronous to aclk
// Notes:   slow filter is a stable-time qualifier
`timescale 1ns/100ps
`include "eic_consts.svh"
module eic_edge_in #(
   parameter int FILT_CYC = `EIC_FILT_CYC
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin,
   input  wire logic fast,
   output logic      rise,
   output logic      fall,
   output logic      level
);
   import eic_pkg::*;

   typedef struct packed {
      logic [23:0] cnt;
      logic        filt;
      logic        prev;
   } eic_edg_s;

   eic_edg_s st;
   eic_edg_s next_st;
   logic     cur;

   // an interrupt input bypasses the slow filter so short pulses are seen
   assign cur   = fast ? pin : st.filt;
   assign level = st.filt;
   assign rise  = cur & ~st.prev;
   assign fall  = ~cur & st.prev;

   always_comb begin
      next_st = st;
      next_st.prev = cur;
      if (fast || pin == st.filt) begin
         next_st.cnt = 24'h000000;
         next_st.filt = fast ? pin : st.filt;
      end else if (st.cnt >= 24'(FILT_CYC - 1)) begin
         next_st.cnt = 24'h000000;
         next_st.filt = pin;
      end else begin
         next_st.cnt = st.cnt + 24'h000001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   a_fast_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      fast && $past(fast) |-> level == $past(pin)) else $error("fast input not followed");
endmodule

/* verilog/eic_top.sv */
// Purpose: edge and source interrupt request logic with AXI4-Lite registers
// Assumes: inputs synchronous to aclk, one handler served at a time
// Notes:   sequencer takes disp_valid/disp_code and returns done
////////////////////////////////////////////////////////////////////////////////
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "eic_consts.svh"
module eic_top #(
   parameter int TBASE_CYC = `EIC_TBASE_CYC,
   parameter int FILT_CYC  = `EIC_FILT_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  ext_edge_inputs,
   input  wire logic [2:0]  encoder_edge_inputs,
   input  wire logic [7:0]  count_match,
   input  wire logic [4:0]  pulse_done,
   output logic             disp_valid,
   output logic [4:0]       disp_code,
   input  wire logic        disp_ready,
   input  wire logic        handler_done,
   output logic [7:0]       input_level,
   output logic             irq,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   import eic_pkg::*;

   typedef struct packed {
      eic_word_t  cfg;
      eic_word_t  src_en;
      logic [7:0] dis;
      logic [6:0] per_a;
      logic [6:0] per_b;
      logic [6:0] per_c;
      eic_word_t  pend;
      logic [1:0] stat;
      logic [1:0] mask;
      logic [16:0] base;
      logic       base_tick;
      eic_disp_e  ds;
      logic [4:0] code;
      logic       aw_got;
      logic [7:0] aw;
      logic       w_got;
      eic_word_t  wd;
      logic       bv;
      logic [1:0] bresp;
      logic       rv;
      eic_word_t  rd;
      logic [1:0] rresp;
   } eic_top_s;

   eic_top_s   st;
   eic_top_s   next_st;
   logic [7:0] pins;
   logic [7:0] fast;
   logic [7:0] rise;
   logic [7:0] fall;
   logic [7:0] in_dis;
   logic [2:0] per_tick;
   logic [7:0] in_ok;
   eic_word_t  event_v;
   eic_word_t  wmask;
   logic       motion;
   logic       wr;

   assign motion = st.cfg[`EIC_CFG_MOTION];

   ////////////////////////////////////////////////////////////////////////////
   // edge inputs
   generate
      for (genvar i = 0; i < 8; i++) begin : g_in
         // motion variant has only three encoder inputs
         assign in_ok[i] = motion ? (i < 3) : 1'b1;
         assign pins[i] = (motion && i < 3) ? encoder_edge_inputs[i % 3]
                                            : ext_edge_inputs[i];
         assign fast[i] = in_ok[i] &&
            (st.src_en[`EIC_SRC_FALL + i] || st.src_en[`EIC_SRC_RISE + i]);
         assign in_dis[i] = st.dis[i] || !in_ok[i];
         eic_edge_in #(.FILT_CYC(FILT_CYC)) u_in (
            .aclk    (aclk),
            .aresetn (aresetn),
            .pin     (pins[i]),
            .fast    (fast[i]),
            .rise    (rise[i]),
            .fall    (fall[i]),
            .level   (input_level[i])
         );
         // code bit 3 = 0 for falling, 1 for rising
         assign event_v[`EIC_SRC_FALL + i] = fall[i] && !in_dis[i];
         assign event_v[`EIC_SRC_RISE + i] = rise[i] && !in_dis[i];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // periodic sources
   eic_periodic u_pa (.aclk(aclk), .aresetn(aresetn),
      .en(st.src_en[`EIC_SRC_PER]), .base_tick(st.base_tick), .period(st.per_a),
      .tick(per_tick[0]));
   eic_periodic u_pb (.aclk(aclk), .aresetn(aresetn),
      .en(st.src_en[`EIC_SRC_PER + 1]), .base_tick(st.base_tick), .period(st.per_b),
      .tick(per_tick[1]));
   eic_periodic u_pc (.aclk(aclk), .aresetn(aresetn),
      .en(st.src_en[`EIC_SRC_PER + 2]), .base_tick(st.base_tick), .period(st.per_c),
      .tick(per_tick[2]));

   // per-timer disables in cfg bits 4..6; counter and pulse groups share one each
   assign event_v[`EIC_SRC_PER +: 3] = per_tick &
      ~st.cfg[`EIC_CFG_PER_EN +: 3];
   assign event_v[`EIC_SRC_CNT +: 8] = count_match &
      {8{~st.cfg[`EIC_CFG_CNT_DIS]}};
   assign event_v[`EIC_SRC_PLS +: 5] = pulse_done &
      (motion ? 5'h07 : 5'h1F) & {5{~st.cfg[`EIC_CFG_PLS_DIS]}};

   ////////////////////////////////////////////////////////////////////////////
   // priority pick and dispatch
   function automatic logic [4:0] first_set(input eic_word_t v);
      logic [4:0] r;
      r = 5'h00;
      for (int k = `EIC_NSRC - 1; k >= 0; k--) begin
         if (v[k]) begin
            r = 5'(k);
         end
      end
      return r;
   endfunction

   assign disp_valid = (st.ds == EIC_ISSUE);
   assign disp_code  = st.code;
   assign irq        = |(st.stat & st.mask);

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   assign s_axi_awready = !st.aw_got && !st.bv;
   assign s_axi_wready  = !st.w_got && !st.bv;
   assign s_axi_bvalid  = st.bv;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = !st.rv;
   assign s_axi_rvalid  = st.rv;
   assign s_axi_rdata   = st.rd;
   assign s_axi_rresp   = st.rresp;
   assign wr = st.aw_got && st.w_got && !st.bv;

   generate
      for (genvar b = 0; b < 4; b++) begin : g_ws
         // byte lanes without a strobe land as zero rather than stale data
         assign wmask[8*b +: 8] = {8{s_axi_wstrb[b]}};
      end
   endgenerate

   always_comb begin
      next_st = st;
      next_st.base_tick = 1'b0;
      if (st.base >= 17'(TBASE_CYC - 1)) begin
         next_st.base = 17'h00000;
         next_st.base_tick = 1'b1;
      end else begin
         next_st.base = st.base + 17'h00001;
      end
      // set wins over the dispatch clear
      next_st.pend = (st.pend | event_v);
      if (|(st.pend & event_v)) begin
         next_st.stat[`EIC_STAT_OVR] = 1'b1;
      end
      unique case (st.ds)
         EIC_IDLE: begin
            // no wait for the scan: pick as soon as anything pends
            if (st.cfg[`EIC_CFG_GIE] && |st.pend) begin
               next_st.code = first_set(st.pend);
               next_st.ds = EIC_ISSUE;
            end
         end
         EIC_ISSUE: begin
            if (disp_ready) begin
               next_st.pend[st.code] = event_v[st.code];
               next_st.stat[`EIC_STAT_DISP] = 1'b1;
               next_st.ds = EIC_BUSY;
            end
         end
         EIC_BUSY: begin
            if (handler_done) begin
               next_st.ds = EIC_IDLE;
            end
         end
         default: begin
            next_st.ds = EIC_IDLE;
         end
      endcase
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_got = 1'b1;
         next_st.aw = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_got = 1'b1;
         next_st.wd = s_axi_wdata & wmask;
      end
      if (st.bv && s_axi_bready) begin
         next_st.bv = 1'b0;
      end
      if (wr) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bv = 1'b1;
         next_st.bresp = 2'h0;
         unique case (st.aw)
            `EIC_OFS_CFG:   next_st.cfg = st.wd;
            `EIC_OFS_DIS:   next_st.dis = st.wd[7:0];
            `EIC_OFS_PER_A: next_st.per_a = st.wd[6:0];
            `EIC_OFS_PER_B: next_st.per_b = st.wd[6:0];
            `EIC_OFS_PER_C: next_st.per_c = st.wd[6:0];
            `EIC_OFS_MASK:  next_st.mask = st.wd[1:0];
            `EIC_OFS_STAT: begin
               // write one to clear; a new event in the same cycle stays set
               next_st.stat = next_st.stat & ~(st.wd[1:0] & st.stat);
               if (|(st.pend & event_v)) begin
                  next_st.stat[`EIC_STAT_OVR] = 1'b1;
               end
               if (st.ds == EIC_ISSUE && disp_ready) begin
                  next_st.stat[`EIC_STAT_DISP] = 1'b1;
               end
            end
            `EIC_OFS_ACK:   next_st.src_en = st.wd;
            default:        next_st.bresp = 2'h2;
         endcase
      end
      if (st.rv && s_axi_rready) begin
         next_st.rv = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_st.rv = 1'b1;
         next_st.rresp = 2'h0;
         unique case (s_axi_araddr)
            `EIC_OFS_CFG:   next_st.rd = st.cfg;
            `EIC_OFS_DIS:   next_st.rd = {24'h000000, st.dis};
            `EIC_OFS_PER_A: next_st.rd = {25'h0000000, st.per_a};
            `EIC_OFS_PER_B: next_st.rd = {25'h0000000, st.per_b};
            `EIC_OFS_PER_C: next_st.rd = {25'h0000000, st.per_c};
            `EIC_OFS_STAT:  next_st.rd = {30'h00000000, st.stat};
            `EIC_OFS_MASK:  next_st.rd = {30'h00000000, st.mask};
            `EIC_OFS_ACK:   next_st.rd = st.src_en;
            `EIC_OFS_PEND:  next_st.rd = st.pend;
            `EIC_OFS_FILT:  next_st.rd = {24'h000000, input_level};
            default: begin
               next_st.rd = 32'h00000000;
               next_st.rresp = 2'h2;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.ds <= EIC_IDLE;
         st.dis <= 8'hFF;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_dis_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
      st.dis[0] |-> !event_v[`EIC_SRC_FALL] && !event_v[`EIC_SRC_RISE])
      else $error("disabled input raised an event");
   a_pend_latch: assert property (@(posedge aclk) disable iff (!aresetn)
      event_v[5] |=> st.pend[5]) else $error("event not latched");
   a_disp_prompt: assert property (@(posedge aclk) disable iff (!aresetn)
      st.ds == EIC_IDLE && st.cfg[0] && |st.pend |=> disp_valid)
      else $error("pending request not dispatched at once");
   a_no_gie: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(disp_valid) |-> $past(st.cfg[0])) else $error("dispatch without enable");
   a_prio_order: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(disp_valid) |-> ($past(st.pend) & ((32'h00000001 << disp_code) - 32'h1)) == 0)
      else $error("priority order broken");
   a_motion_in: assert property (@(posedge aclk) disable iff (!aresetn)
      motion |-> event_v[15:11] == 5'h00 && event_v[7:3] == 5'h00)
      else $error("motion variant raised unused input");
   a_pulse_motion: assert property (@(posedge aclk) disable iff (!aresetn)
      motion |-> event_v[31:30] == 2'h0) else $error("extra pulse source");
   a_cnt_src: assert property (@(posedge aclk) disable iff (!aresetn)
      count_match[0] && !st.cfg[`EIC_CFG_CNT_DIS] |=> st.pend[`EIC_SRC_CNT])
      else $error("count match lost");
endmodule

/* tb/eic_seq_model.sv */
// Purpose: handler sequencer on the dispatch side of the edge interrupt block
// Assumes: disp_valid and disp_code hold until disp_ready is sampled high
// Notes:   lag sets how slowly requests are accepted; codes keeps them in order
`timescale 1ns/100ps
module eic_seq_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       disp_valid,
   input  wire logic [4:0] disp_code,
   output logic            disp_ready,
   output logic            handler_done
);
   int         lag;
   logic [4:0] codes[$];
   initial begin
      lag = 0;
      disp_ready = 1'b0;
      handler_done = 1'b0;
      forever begin
         @(posedge aclk);
         if (aresetn && disp_valid) begin
            // a slow sequencer must still see the request held
            repeat (lag) @(posedge aclk);
            disp_ready <= 1'b1;
            @(posedge aclk);
            codes.push_back(disp_code);
            disp_ready <= 1'b0;
            // only one handler runs at a time
            repeat (3) @(posedge aclk);
            handler_done <= 1'b1;
            @(posedge aclk);
            handler_done <= 1'b0;
         end
      end
   end
endmodule

/* tb/edge_input_interrupt_ctrl_test.sv */
// Purpose: self-checking bench of the edge interrupt block
// Assumes: short timer base and filter counts set on the instance
// Notes:   scenarios run in sequence; each judges its own outcome
`timescale 1ns/100ps
`include "eic_consts.svh"
module edge_input_interrupt_ctrl_test;
   logic        aclk, aresetn, disp_valid, disp_ready, handler_done, irq;
   logic [7:0]  ext, cmatch, level, awaddr, araddr;
   logic [2:0]  enc;
   logic [4:0]  pdone, dcode;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, wresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   int          n_mismatch, checked;

   always #5 aclk = ~aclk;

   eic_top #(.TBASE_CYC(10), .FILT_CYC(8)) dut (
      .aclk(aclk), .aresetn(aresetn), .ext_edge_inputs(ext), .encoder_edge_inputs(enc),
      .count_match(cmatch), .pulse_done(pdone), .disp_valid(disp_valid), .disp_code(dcode),
      .disp_ready(disp_ready), .handler_done(handler_done), .input_level(level), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   eic_seq_model seq (
      .aclk(aclk), .aresetn(aresetn), .disp_valid(disp_valid), .disp_code(dcode),
      .disp_ready(disp_ready), .handler_done(handler_done));

////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw_d, w_d, ok;
      aw_d = 1'b0;
      w_d = 1'b0;
      ok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 50 && !ok; i++) begin
         @(posedge aclk);
         ok = bvalid && aw_d && w_d;
         if (awready && !aw_d) begin
            aw_d = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready && !w_d) begin
            w_d = 1'b1;
            wvalid <= 1'b0;
         end
      end
      if (!ok) n_mismatch++;
      wresp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_d, ok;
      ar_d = 1'b0;
      ok = 1'b0;
      d = 32'hFFFF_FFFF;
      r = 2'h3;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 50 && !ok; i++) begin
         @(posedge aclk);
         if (rvalid && ar_d) begin
            ok = 1'b1;
            d = rdata;
            r = rresp;
         end
         if (arready && !ar_d) begin
            ar_d = 1'b1;
            arvalid <= 1'b0;
         end
      end
      if (!ok) n_mismatch++;
      rready <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axr(a, d, r);
      chk({30'h0, r}, 32'h0);
      chk(d, exp);
   endtask

   // a missing dispatch reads back as all ones, never as a code
   task automatic exp_disp(input logic [4:0] c, input int lim);
      for (int i = 0; i < lim && seq.codes.size() == 0; i++) @(posedge aclk);
      if (seq.codes.size() == 0) chk(32'hFFFF_FFFF, {27'h0, c});
      else chk({27'h0, seq.codes.pop_front()}, {27'h0, c});
   endtask

   task automatic exp_none(input int lim);
      repeat (lim) @(posedge aclk);
      chk(seq.codes.size(), 32'h0);
   endtask

   task automatic irq_is(input logic v);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, {31'h0, v});
   endtask

////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      rd_chk(`EIC_OFS_DIS, 32'hFF);
      rd_chk(`EIC_OFS_PEND, 32'h0);
      axr(8'h28, d, r);
      chk({30'h0, r}, 32'h2);
      chk(d, 32'h0);
      chk({31'h0, irq}, 32'h0);
      axw(8'h28, 32'h0);
      chk({30'h0, wresp}, 32'h2);
   endtask

   task automatic t_edge;
      axw(`EIC_OFS_ACK, 32'h400);
      chk({30'h0, wresp}, 32'h0);
      axw(`EIC_OFS_DIS, 32'hFB);
      @(posedge aclk) ext <= 8'h04;
      exp_none(30);
      rd_chk(`EIC_OFS_PEND, 32'h400);
      axw(`EIC_OFS_CFG, 32'h71);
      exp_disp(5'd10, 40);
      rd_chk(`EIC_OFS_PEND, 32'h0);
      @(posedge aclk) ext <= 8'h00;
      exp_disp(5'd2, 40);
   endtask

   task automatic t_dis;
      axw(`EIC_OFS_DIS, 32'hFF);
      @(posedge aclk) ext <= 8'h04;
      repeat (30) @(posedge aclk);
      ext <= 8'h00;
      exp_none(40);
      rd_chk(`EIC_OFS_PEND, 32'h0);
   endtask

   task automatic t_multi;
      axw(`EIC_OFS_DIS, 32'h7E);
      @(posedge aclk) ext <= 8'h81;
      exp_disp(5'd8, 40);
      exp_disp(5'd15, 40);
      @(posedge aclk) ext <= 8'h00;
      exp_disp(5'd0, 40);
      exp_disp(5'd7, 40);
      axw(`EIC_OFS_DIS, 32'hFF);
   endtask

   task automatic t_src;
      seq.lag = 4;
      @(posedge aclk);
      cmatch <= 8'h81;
      pdone <= 5'h11;
      @(posedge aclk);
      cmatch <= 8'h00;
      pdone <= 5'h00;
      exp_disp(5'd19, 40);
      exp_disp(5'd26, 40);
      exp_disp(5'd27, 40);
      exp_disp(5'd31, 40);
      seq.lag = 0;
   endtask

   task automatic t_irq;
      axw(`EIC_OFS_MASK, 32'h2);
      axw(`EIC_OFS_STAT, 32'h3);
      irq_is(1'b0);
      @(posedge aclk) cmatch <= 8'h02;
      @(posedge aclk) cmatch <= 8'h00;
      exp_disp(5'd20, 40);
      irq_is(1'b1);
      rd_chk(`EIC_OFS_STAT, 32'h2);
      axw(`EIC_OFS_MASK, 32'h0);
      irq_is(1'b0);
      axw(`EIC_OFS_MASK, 32'h2);
      irq_is(1'b1);
      axw(`EIC_OFS_STAT, 32'h2);
      irq_is(1'b0);
   endtask

   // in2 keeps its fast filter while in5 still waits out the slow one
   task automatic t_filt;
      @(posedge aclk) ext <= 8'h24;
      repeat (6) @(posedge aclk);
      chk({24'h0, level}, 32'h04);
      repeat (20) @(posedge aclk);
      rd_chk(`EIC_OFS_FILT, 32'h24);
      ext <= 8'h00;
      exp_none(30);
   endtask

   task automatic t_motion;
      axw(`EIC_OFS_CFG, 32'h73);
      axw(`EIC_OFS_DIS, 32'hFE);
      @(posedge aclk) enc <= 3'b001;
      exp_disp(5'd8, 40);
      @(posedge aclk) enc <= 3'b000;
      exp_disp(5'd0, 40);
      axw(`EIC_OFS_DIS, 32'hFF);
      axw(`EIC_OFS_CFG, 32'h71);
   endtask

   task automatic t_per;
      // the source enable bits also run the periodic counters
      axw(`EIC_OFS_ACK, 32'h50400);
      axw(`EIC_OFS_PER_A, 32'd2);
      axw(`EIC_OFS_CFG, 32'h61);
      exp_disp(5'd16, 60);
      axw(`EIC_OFS_CFG, 32'h71);
      repeat (40) @(posedge aclk);
      seq.codes.delete();
      axw(`EIC_OFS_PER_C, 32'd99);
      axw(`EIC_OFS_CFG, 32'h31);
      exp_disp(5'd18, 1200);
      exp_none(900);
      exp_disp(5'd18, 200);
      axw(`EIC_OFS_CFG, 32'h71);
   endtask

////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      ext = 8'h00;
      enc = 3'b000;
      cmatch = 8'h00;
      pdone = 5'h00;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      n_mismatch = 0;
      checked = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_edge();
      t_dis();
      t_multi();
      t_src();
      t_irq();
      t_filt();
      t_motion();
      t_per();
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      give_verdict();
   end
endmodule
